// File: core/uetc_top.v
// USB function endpoint transmit control with hub status-change endpoint
//
// Function
// - IN token while no packet is ready gets a NAK handshake.
// - IN token with a ready packet shifts it out of the FIFO.
// - Non-isochronous function send ending in a host handshake raises transmit-done; hub endpoint sends do not.
// - Transmit-done raised on ACK and on error; status tells them apart.
// - Isochronous: no handshake, no transmit-done; status updated at frame end.
// - At most one isochronous packet per frame.
// - Control bit 3 selects isochronous (1) or non-isochronous (0).
// - Non-isochronous only: host handshake decides toggling of the sequence bit.
// - Control bit 2 selects automatic (1) or firmware (0) marker management.
// - Without auto mode, advance-marker and reverse-pointer controls move them.
// - Failed isochronous packet dropped; failed non-isochronous packet retried.
// - Every start-of-frame raises the data preparation interrupt.
// - Only tokens carrying our assigned address start a transfer.
// - Port connect detect is reported through hub endpoint 1.
// - Clearing a connect-change flag clears its bit in endpoint 1 data.
// - Function and hub addresses reset to zero.
`timescale 1ns/1ps
`include "uetc_map.vh"

module uetc_top #(
    parameter FIFO_AW = 6,
    parameter NUM_PORTS = 5,
    parameter [3:0] FUNC_EP = 4'h1
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,

    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,

    // Decoded tokens from the serial engine
    input wire tok_valid,
    input wire [3:0] tok_pid,
    input wire [6:0] tok_addr,
    input wire [3:0] tok_ep,

    // Host handshake after a data packet
    input wire hsk_valid,
    input wire hsk_ack,

    // Data packet stream to the serial engine
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_last,
    output reg tx_zero_len,
    output reg tx_data1,
    input wire tx_ready,
    output reg tx_nak,

    // Hub downstream ports
    input wire [NUM_PORTS:1] port_connect_detect,

    // Interrupt
    output reg irq
);

    localparam DEPTH = 1 << FIFO_AW;

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_HSK = 3'b100;

    reg [7:0] mem [0:DEPTH-1];
    reg [FIFO_AW:0] wr_ptr_reg;
    reg [FIFO_AW:0] rd_ptr_reg;
    reg [FIFO_AW:0] marker_reg;

    reg [FIFO_AW:0] pkt_len_reg;
    reg [FIFO_AW:0] left_reg;
    reg [3:0] ctl_reg;

    reg ready_reg;
    reg ack_reg;
    reg err_reg;
    reg seq_reg;
    reg hub_seq_reg;

    reg iso_sent_reg;
    reg iso_sent_st_reg;
    reg iso_miss_st_reg;

    reg [6:0] function_address_reg_reg;
    reg [6:0] haddr_reg;
    reg [2:0] int_stat_reg;
    reg [2:0] int_mask_reg;

    reg [2:0] state_reg;
    reg hub_sel_reg;
    reg [NUM_PORTS:1] port_chg_reg;

    reg [31:0] rd_mux;
    reg map_hit;

    wire setup = psel & ~penable;
    wire access = psel & penable & ce;
    wire wr_en = access & pwrite;

    wire tok_in = ce & tok_valid & (tok_pid == `UETC_PID_IN);
    wire tok_sof = ce & tok_valid & (tok_pid == `UETC_PID_SOF);
    wire func_hit = (tok_addr == function_address_reg_reg) && (tok_ep == FUNC_EP);
    wire hub_hit = (tok_addr == haddr_reg) && (tok_ep == `UETC_HUB_STATUS_EP);

    wire iso_mode = ctl_reg[`UETC_CTL_ISO_BIT];
    wire auto_tx_marker_mode = ctl_reg[`UETC_CTL_AUTO_BIT];
    // Extra pointer bit tells full from empty
    wire [FIFO_AW:0] fill = wr_ptr_reg - marker_reg;
    wire fifo_full = (fill == DEPTH[FIFO_AW:0]);
    // Bit 0 is the hub itself
    wire [7:0] hub_bitmap = {{(7-NUM_PORTS){1'b0}}, port_chg_reg, 1'b0};

    wire [2:0] int_clr = (wr_en && paddr == `UETC_INT_STATUS) ? pwdata[2:0] : 3'h0;
    wire ctl_wr = wr_en && (paddr == `UETC_TX_FIFO_CONTROL);
    // One iso packet per frame
    wire func_start = tok_in & func_hit & (state_reg == ST_IDLE) & ready_reg
        & ~(iso_mode & iso_sent_reg);
    // Late handshakes ignored
    wire hsk_done = ce & hsk_valid & (state_reg == ST_HSK);
    wire tx_done_evt = hsk_done & ~hub_sel_reg;

    // Zero wait states
    assign pready = psel & penable & ce;

    // Hub port connect-change flags; a detect in the clear cycle survives
    genvar gi;
    generate
        for (gi = 1; gi <= NUM_PORTS; gi = gi + 1) begin : g_port
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    port_chg_reg[gi] <= 1'b0;
                end else if (ce) begin
                    if (port_connect_detect[gi]) begin
                        port_chg_reg[gi] <= 1'b1;
                    end else if (wr_en && paddr == `UETC_PORT_CHANGE && pwdata[gi]) begin
                        port_chg_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Register read mux
    always @* begin
        rd_mux = 32'h0000_0000;
        map_hit = 1'b1;
        case (paddr)
            `UETC_TX_FIFO_CONTROL: rd_mux[3:0] = {ctl_reg[3:2], 2'b00};
            `UETC_TX_FIFO_DATA: rd_mux[FIFO_AW:0] = fill;
            `UETC_TX_PKT_LEN: rd_mux[FIFO_AW:0] = pkt_len_reg;
            `UETC_TX_STATUS: rd_mux[5:0] = {iso_miss_st_reg, iso_sent_st_reg, seq_reg,
                err_reg, ack_reg, ready_reg};
            `UETC_FUNC_ADDR: rd_mux[6:0] = function_address_reg_reg;
            `UETC_HUB_ADDR: rd_mux[6:0] = haddr_reg;
            `UETC_INT_STATUS: rd_mux[2:0] = int_stat_reg;
            `UETC_INT_MASK: rd_mux[2:0] = int_mask_reg;
            `UETC_PORT_CHANGE: rd_mux[7:0] = hub_bitmap;
            default: map_hit = 1'b0;
        endcase
    end

    // APB read data and error captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~map_hit;
        end
    end

    // FIFO storage; writes beyond a full FIFO are dropped
    always @(posedge pclk) begin
        if (wr_en && paddr == `UETC_TX_FIFO_DATA && !fifo_full) begin
            mem[wr_ptr_reg[FIFO_AW-1:0]] <= pwdata[7:0];
        end
    end

    // Configuration, addresses, interrupt mask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            function_address_reg_reg <= `UETC_ADDR_RESET;
            haddr_reg <= `UETC_ADDR_RESET;
            int_mask_reg <= 3'h0;

            pkt_len_reg <= {(FIFO_AW+1){1'b0}};
            wr_ptr_reg <= {(FIFO_AW+1){1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `UETC_FUNC_ADDR: function_address_reg_reg <= pwdata[6:0];
                `UETC_HUB_ADDR: haddr_reg <= pwdata[6:0];
                `UETC_INT_MASK: int_mask_reg <= pwdata[2:0];
                `UETC_TX_PKT_LEN: pkt_len_reg <= pwdata[FIFO_AW:0];
                `UETC_TX_FIFO_DATA: begin
                    if (!fifo_full) begin
                        wr_ptr_reg <= wr_ptr_reg + 1'b1;
                    end
                end
                default: wr_ptr_reg <= wr_ptr_reg;
            endcase
        end
    end

    // Sticky interrupt flags, set wins over write-one-to-clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= 3'h0;
            irq <= 1'b0;
        end else if (ce) begin
            int_stat_reg <= (int_stat_reg & ~int_clr)
                | {|port_connect_detect, tok_sof, tx_done_evt};
            // Rises on the same edge as the flag that sets it
            irq <= |(((int_stat_reg & ~int_clr)
                | {|port_connect_detect, tok_sof, tx_done_evt}) & int_mask_reg);
        end
    end

    // Transmit sequencer, FIFO read side and transfer status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            ctl_reg <= `UETC_CTL_RESET;

            rd_ptr_reg <= {(FIFO_AW+1){1'b0}};
            marker_reg <= {(FIFO_AW+1){1'b0}};
            left_reg <= {(FIFO_AW+1){1'b0}};

            ready_reg <= 1'b0;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            seq_reg <= 1'b0;
            hub_seq_reg <= 1'b0;
            iso_sent_reg <= 1'b0;
            iso_sent_st_reg <= 1'b0;
            iso_miss_st_reg <= 1'b0;
            hub_sel_reg <= 1'b0;

            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            tx_zero_len <= 1'b0;
            tx_data1 <= 1'b0;
            tx_nak <= 1'b0;
        end else if (ce) begin
            // One-cycle pulse
            tx_nak <= 1'b0;
            if (ctl_wr) begin
                ctl_reg[3:2] <= pwdata[3:2];
            end

            // Manual marker controls only act outside a transfer
            if (ctl_wr && !pwdata[`UETC_CTL_AUTO_BIT] && state_reg == ST_IDLE) begin
                if (pwdata[`UETC_CTL_ADV_RM_BIT]) begin
                    marker_reg <= rd_ptr_reg;
                end else if (pwdata[`UETC_CTL_REV_RP_BIT]) begin
                    rd_ptr_reg <= marker_reg;
                end
            end

            // Length write arms the packet; FIFO must already hold it
            if (wr_en && paddr == `UETC_TX_PKT_LEN) begin
                ready_reg <= 1'b1;
            end

            // Frame boundary closes the isochronous status of the frame
            if (tok_sof) begin
                iso_sent_reg <= 1'b0;
                if (iso_mode) begin
                    iso_sent_st_reg <= iso_sent_reg;
                    iso_miss_st_reg <= ~iso_sent_reg;
                end
            end

            case (state_reg)
                // Function wins over hub
                ST_IDLE: begin
                    if (func_start) begin
                        hub_sel_reg <= 1'b0;
                        tx_valid <= 1'b1;
                        tx_data <= mem[rd_ptr_reg[FIFO_AW-1:0]];
                        tx_data1 <= iso_mode ? 1'b0 : seq_reg;
                        tx_zero_len <= (pkt_len_reg == 0);
                        tx_last <= (pkt_len_reg <= 1);
                        left_reg <= pkt_len_reg;
                        if (pkt_len_reg != 0) begin
                            rd_ptr_reg <= rd_ptr_reg + 1'b1;
                        end
                        state_reg <= ST_SEND;
                    end else if (tok_in && func_hit) begin
                        tx_nak <= 1'b1;
                    end else if (tok_in && hub_hit) begin
                        if (|port_chg_reg) begin
                            hub_sel_reg <= 1'b1;
                            tx_valid <= 1'b1;
                            tx_data <= hub_bitmap;
                            tx_data1 <= hub_seq_reg;
                            tx_zero_len <= 1'b0;
                            tx_last <= 1'b1;
                            left_reg <= {{FIFO_AW{1'b0}}, 1'b1};
                            state_reg <= ST_SEND;
                        end else begin
                            tx_nak <= 1'b1;
                        end
                    end
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        if (tx_last) begin
                            tx_valid <= 1'b0;
                            tx_last <= 1'b0;
                            tx_zero_len <= 1'b0;
                            if (!hub_sel_reg && iso_mode) begin
                                // No handshake: drop the packet either way
                                ready_reg <= 1'b0;
                                iso_sent_reg <= 1'b1;
                                if (auto_tx_marker_mode) begin
                                    marker_reg <= rd_ptr_reg;
                                end
                                state_reg <= ST_IDLE;
                            end else begin
                                state_reg <= ST_HSK;
                            end
                        end else begin
                            tx_data <= mem[rd_ptr_reg[FIFO_AW-1:0]];
                            rd_ptr_reg <= rd_ptr_reg + 1'b1;
                            left_reg <= left_reg - 1'b1;
                            tx_last <= (left_reg == 2);
                        end
                    end
                end
                ST_HSK: begin
                    if (hsk_valid) begin
                        state_reg <= ST_IDLE;
                        if (hub_sel_reg) begin
                            // Separate hub sequence bit
                            hub_seq_reg <= hub_seq_reg ^ hsk_ack;
                        end else begin
                            ack_reg <= hsk_ack;
                            err_reg <= ~hsk_ack;
                            seq_reg <= seq_reg ^ hsk_ack;
                            // Error keeps packet armed
                            if (hsk_ack) begin
                                ready_reg <= 1'b0;
                                if (auto_tx_marker_mode) begin
                                    marker_reg <= rd_ptr_reg;
                                end
                            end else if (auto_tx_marker_mode) begin
                                // Rewind so the host can retry the same data
                                rd_ptr_reg <= marker_reg;
                            end
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule

// File: core/uetc_map.vh
// Register offsets, field positions and reset values of the endpoint transmit control
`ifndef UETC_MAP_VH
`define UETC_MAP_VH

// Register byte offsets (APB, one 32-bit word each)
`define UETC_TX_FIFO_CONTROL  8'h00
`define UETC_TX_FIFO_DATA     8'h04
`define UETC_TX_PKT_LEN       8'h08
`define UETC_TX_STATUS        8'h0C
`define UETC_FUNC_ADDR        8'h10
`define UETC_HUB_ADDR         8'h14
`define UETC_INT_STATUS       8'h18
`define UETC_INT_MASK         8'h1C
`define UETC_PORT_CHANGE      8'h20

// tx_fifo_control fields
`define UETC_CTL_ISO_BIT      3
`define UETC_CTL_AUTO_BIT     2
`define UETC_CTL_ADV_RM_BIT   1
`define UETC_CTL_REV_RP_BIT   0
`define UETC_CTL_RESET        4'h4

// tx status fields
`define UETC_ST_READY_BIT     0
`define UETC_ST_ACK_BIT       1
`define UETC_ST_ERR_BIT       2
`define UETC_ST_SEQ_BIT       3
`define UETC_ST_ISO_SENT_BIT  4
`define UETC_ST_ISO_MISS_BIT  5

// Interrupt status / mask fields
`define UETC_INT_TXDONE_BIT   0
`define UETC_INT_SOF_BIT      1
`define UETC_INT_HUBCHG_BIT   2

// Address reset value
`define UETC_ADDR_RESET       7'h00

// Token PIDs as published by the USB protocol
`define UETC_PID_IN           4'h9
`define UETC_PID_SOF          4'h5

// Hub status change endpoint number
`define UETC_HUB_STATUS_EP    4'h1

`endif

// File: verification/uetc_host_model.sv
// Host-side model: issues tokens and handshakes, collects data beats
`timescale 1ns/1ps
module uetc_host_model (
    // Clock
    input wire pclk,
    // Tokens and handshake
    output logic tok_valid,
    output logic [3:0] tok_pid,
    output logic [6:0] tok_addr,
    output logic [3:0] tok_ep,
    output logic hsk_valid,
    output logic hsk_ack,
    // Data beats
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_data1,
    output logic tx_ready,
    input wire tx_nak
);
    logic [7:0] rx_q[$];
    logic rx_d1;
    logic got_nak;
    initial begin
        {tok_valid, tok_pid, tok_addr, tok_ep, hsk_valid, hsk_ack} = '0;
        tx_ready = 1'b1;
    end
    task automatic tok(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep);
        @(posedge pclk);
        {tok_valid, tok_pid, tok_addr, tok_ep} <= {1'b1, pid, a, ep};
        @(posedge pclk);
        // Stale fields inverted so nothing can lean on them
        {tok_valid, tok_pid, tok_addr, tok_ep} <= {1'b0, ~pid, ~a, ~ep};
    endtask
    task automatic xfer(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep,
                        input logic stall);
        logic fin;
        int i;
        rx_q.delete();
        got_nak = 1'b0;
        fin = 1'b0;
        tok(pid, a, ep);
        for (i = 0; i < 40 && !fin; i++) begin
            @(negedge pclk);
            if (tx_nak) begin
                got_nak = 1'b1;
                fin = 1'b1;
            end else if (tx_valid && tx_ready) begin
                if (rx_q.size() == 0) rx_d1 = tx_data1;
                rx_q.push_back(tx_data);
                fin = tx_last;
            end
            @(posedge pclk);
            // Slow host is ready on every other cycle
            tx_ready <= stall ? ~tx_ready : 1'b1;
        end
    endtask
    task automatic hsk(input logic ack);
        @(posedge pclk);
        {hsk_valid, hsk_ack} <= {1'b1, ack};
        @(posedge pclk);
        {hsk_valid, hsk_ack} <= {1'b0, ~ack};
    endtask
endmodule

// File: verification/uetc_sva.sv
// Assertions on the endpoint transmit control ports
`timescale 1ns/1ps
`include "uetc_map.vh"
module uetc_sva #(
    parameter [3:0] FUNC_EP = 4'h1
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Tokens and handshake
    input wire tok_valid,
    input wire [3:0] tok_pid,
    input wire [6:0] tok_addr,
    input wire [3:0] tok_ep,
    input wire hsk_valid,
    // Data stream and interrupt
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_zero_len,
    input wire tx_ready,
    input wire tx_nak,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [6:0] fa_q, ha_q;
    logic iso_q, sofm_q, wait_q;
    wire wr = psel && penable && pwrite && ce;
    wire in_tok = tok_valid && tok_pid == `UETC_PID_IN;
    wire free = ce && !tx_valid && !wait_q;
    wire hit_f = tok_addr == fa_q && tok_ep == FUNC_EP;
    wire hit = hit_f || (tok_addr == ha_q && tok_ep == `UETC_HUB_STATUS_EP);
    // Shadow of the address, mode and mask writes, so tokens can be judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {fa_q, ha_q, iso_q, sofm_q, wait_q} <= '0;
        end else begin
            if (wr && paddr == `UETC_FUNC_ADDR) fa_q <= pwdata[6:0];
            if (wr && paddr == `UETC_HUB_ADDR) ha_q <= pwdata[6:0];
            if (wr && paddr == `UETC_TX_FIFO_CONTROL) iso_q <= pwdata[`UETC_CTL_ISO_BIT];
            if (wr && paddr == `UETC_INT_MASK) sofm_q <= pwdata[`UETC_INT_SOF_BIT];
            if (tx_valid && tx_ready && tx_last && !iso_q) wait_q <= 1'b1;
            else if (hsk_valid) wait_q <= 1'b0;
        end
    end
    property p_answer; in_tok && hit && free |=> tx_nak != tx_valid; endproperty
    property p_nak; tx_nak |=> !tx_nak; endproperty
    property p_excl; tx_nak |-> !tx_valid; endproperty
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    property p_zlp; tx_valid && tx_zero_len |-> tx_last; endproperty
    property p_ignore; tok_valid && !hit && free |=> !tx_valid && !tx_nak; endproperty
    property p_addr; psel && pready && !pwrite && paddr == `UETC_FUNC_ADDR |-> prdata[6:0] == fa_q;
    endproperty
    property p_sof; tok_valid && tok_pid == `UETC_PID_SOF && sofm_q |-> ##[1:3] irq; endproperty
    property p_rdy; pready == (psel && penable && ce); endproperty
    property p_unmap; psel && pready && paddr == 8'h24 |-> pslverr; endproperty
    a_answer: assert property (p_answer) else $error("token got no answer");
    a_nak: assert property (p_nak) else $error("nak longer than one cycle");
    a_excl: assert property (p_excl) else $error("nak during data");
    a_hold: assert property (p_hold) else $error("beat changed while stalled");
    a_zlp: assert property (p_zlp) else $error("empty packet not last");
    a_ignore: assert property (p_ignore) else $error("foreign token answered");
    a_addr: assert property (p_addr) else $error("function address readback");
    a_sof: assert property (p_sof) else $error("frame start raised no irq");
    a_rdy: assert property (p_rdy) else $error("pready wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped read not flagged");
    c_nak: cover property (tx_nak);
    c_last: cover property (tx_valid && tx_last && tx_ready);
    c_irq: cover property (irq);
endmodule
bind uetc_top uetc_sva #(.FUNC_EP(FUNC_EP)) uetc_sva_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
    .tok_ep(tok_ep), .hsk_valid(hsk_valid), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_zero_len(tx_zero_len), .tx_ready(tx_ready), .tx_nak(tx_nak),
    .irq(irq)
);

// File: verification/tb_top.sv
// Self-checking bench for the endpoint transmit control
`timescale 1ns/1ps
`include "uetc_map.vh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_e;
    logic [7:0] paddr, tx_data;
    logic [31:0] pwdata, prdata, rd_d;
    logic tok_valid, hsk_valid, hsk_ack, tx_valid, tx_last, tx_zero_len, tx_data1, tx_ready;
    logic tx_nak, ce;
    logic [3:0] tok_pid, tok_ep;
    logic [6:0] tok_addr;
    logic [5:1] pcd;
    int err_count = 0;
    int n_tests = 0;
    uetc_top uetc_top_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
        .tok_ep(tok_ep), .hsk_valid(hsk_valid), .hsk_ack(hsk_ack), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_zero_len(tx_zero_len), .tx_data1(tx_data1),
        .tx_ready(tx_ready), .tx_nak(tx_nak), .port_connect_detect(pcd), .irq(irq)
    );
    uetc_host_model uetc_host_model_i (
        .pclk(pclk), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
        .tok_ep(tok_ep), .hsk_valid(hsk_valid), .hsk_ack(hsk_ack), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_data1(tx_data1), .tx_ready(tx_ready),
        .tx_nak(tx_nak)
    );
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd_d = prdata;
        rd_e = pslverr;
        {psel, penable} <= 2'b00;
        if (i == 20) begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_d & m, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        #1 chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    task automatic xin(input logic [6:0] a, input logic [3:0] ep, input logic st);
        uetc_host_model_i.xfer(`UETC_PID_IN, a, ep, st);
    endtask
    task automatic nak_is(input logic e);
        chk("nak", {31'h0, uetc_host_model_i.got_nak}, {31'h0, e});
    endtask
    task automatic pkt(input int n, input logic [7:0] b0, input logic [7:0] b1);
        chk("beats", uetc_host_model_i.rx_q.size(), n);
        if (n > 0) chk("byte0", {24'h0, uetc_host_model_i.rx_q[0]}, {24'h0, b0});
        if (n > 1) chk("byte1", {24'h0, uetc_host_model_i.rx_q[1]}, {24'h0, b1});
    endtask
    task automatic d1_is(input logic e);
        chk("data1", {31'h0, uetc_host_model_i.rx_d1}, {31'h0, e});
    endtask
    task automatic t_reset();
        rdc("function_address_reg", `UETC_FUNC_ADDR, 32'h7F, 32'h0);
        rdc("haddr", `UETC_HUB_ADDR, 32'h7F, 32'h0);
        rdc("ctl", `UETC_TX_FIFO_CONTROL, 32'hF, 32'h4);
        rdc("unmapped", 8'h24, 32'hFFFFFFFF, 32'h0);
        chk("slverr", {31'h0, rd_e}, 32'h1);
    endtask
    task automatic t_nak();
        wr(`UETC_FUNC_ADDR, 32'h05);
        xin(7'h33, 4'h1, 1'b0);
        nak_is(1'b0);
        pkt(0, 8'h00, 8'h00);
        xin(7'h05, 4'h1, 1'b0);
        nak_is(1'b1);
    endtask
    task automatic t_ack();
        wr(`UETC_INT_STATUS, 32'h7);
        wr(`UETC_TX_FIFO_DATA, 32'hA5);
        wr(`UETC_TX_FIFO_DATA, 32'h3C);
        wr(`UETC_TX_PKT_LEN, 32'h2);
        xin(7'h05, 4'h1, 1'b1);
        pkt(2, 8'hA5, 8'h3C);
        d1_is(1'b0);
        uetc_host_model_i.hsk(1'b1);
        rdc("st_ack", `UETC_TX_STATUS, 32'hF, 32'hA);
        rdc("int_done", `UETC_INT_STATUS, 32'h1, 32'h1);
        irq_is(1'b0);
        wr(`UETC_INT_MASK, 32'h1);
        irq_is(1'b1);
        wr(`UETC_INT_STATUS, 32'h1);
        irq_is(1'b0);
        wr(`UETC_INT_MASK, 32'h0);
    endtask
    task automatic t_err();
        wr(`UETC_INT_STATUS, 32'h7);
        wr(`UETC_TX_FIFO_DATA, 32'h5A);
        wr(`UETC_TX_PKT_LEN, 32'h1);
        xin(7'h05, 4'h1, 1'b0);
        pkt(1, 8'h5A, 8'h00);
        uetc_host_model_i.hsk(1'b0);
        rdc("int_err", `UETC_INT_STATUS, 32'h1, 32'h1);
        rdc("st_err", `UETC_TX_STATUS, 32'hD, 32'hD);
        // Retry must resend the same byte under the same sequence bit
        xin(7'h05, 4'h1, 1'b0);
        pkt(1, 8'h5A, 8'h00);
        d1_is(1'b1);
        uetc_host_model_i.hsk(1'b1);
        rdc("st_retry", `UETC_TX_STATUS, 32'h9, 32'h0);
    endtask
    task automatic t_iso();
        wr(`UETC_TX_FIFO_CONTROL, 32'hC);
        wr(`UETC_INT_STATUS, 32'h7);
        wr(`UETC_INT_MASK, 32'h2);
        uetc_host_model_i.tok(`UETC_PID_SOF, 7'h33, 4'h0);
        irq_is(1'b1);
        rdc("int_sof", `UETC_INT_STATUS, 32'h2, 32'h2);
        wr(`UETC_INT_MASK, 32'h0);
        wr(`UETC_TX_FIFO_DATA, 32'h77);
        wr(`UETC_TX_PKT_LEN, 32'h1);
        xin(7'h05, 4'h1, 1'b0);
        pkt(1, 8'h77, 8'h00);
        wr(`UETC_TX_FIFO_DATA, 32'h66);
        wr(`UETC_TX_PKT_LEN, 32'h1);
        xin(7'h05, 4'h1, 1'b0);
        nak_is(1'b1);
        rdc("int_iso", `UETC_INT_STATUS, 32'h1, 32'h0);
        uetc_host_model_i.tok(`UETC_PID_SOF, 7'h33, 4'h0);
        rdc("st_iso", `UETC_TX_STATUS, 32'h10, 32'h10);
        xin(7'h05, 4'h1, 1'b0);
        pkt(1, 8'h66, 8'h00);
        wr(`UETC_TX_FIFO_CONTROL, 32'h4);
    endtask
    task automatic t_hub();
        wr(`UETC_HUB_ADDR, 32'h0A);
        wr(`UETC_INT_STATUS, 32'h7);
        @(posedge pclk);
        pcd <= 5'b00100;
        @(posedge pclk);
        pcd <= 5'b00000;
        rdc("int_hub", `UETC_INT_STATUS, 32'h4, 32'h4);
        xin(7'h0A, `UETC_HUB_STATUS_EP, 1'b0);
        pkt(1, 8'h08, 8'h00);
        uetc_host_model_i.hsk(1'b1);
        wr(`UETC_PORT_CHANGE, 32'h8);
        xin(7'h0A, `UETC_HUB_STATUS_EP, 1'b0);
        nak_is(1'b1);
    endtask
    task automatic t_ce();
        wr(`UETC_INT_STATUS, 32'h7);
        @(posedge pclk);
        {ce, pcd} <= {1'b0, 5'b00010};
        repeat (2) @(posedge pclk);
        {ce, pcd} <= {1'b1, 5'b00000};
        rdc("ce_int", `UETC_INT_STATUS, 32'h4, 32'h0);
        rdc("ce_flag", `UETC_PORT_CHANGE, 32'hFF, 32'h0);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pcd, rd_d, rd_e} = '0;
        ce = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_nak();
        t_ack();
        t_err();
        t_iso();
        t_hub();
        t_ce();
        end_of_test();
    end
endmodule
